// [hdl/smbus_slave_regs.vh]
`ifndef SMBUS_SLAVE_REGS_VH
`define SMBUS_SLAVE_REGS_VH

// status vectors shown to software
`define SV_SLV_DATA 4'h0
`define SV_STOP_LOST 4'h1
`define SV_SLV_ADDR 4'h2
`define SV_SLV_TX_BYTE 4'h4
`define SV_SLV_TX_STOP 4'h5

// address byte layout: address in bits 7..1, direction in bit 0
`define ADDR_DIR_BIT 0
`define DIR_READ 1'b1

// bits per byte on the wire, ack slot follows
`define BYTE_BITS 4'h8

// kinds of arbitration loss reported by the master engine
`define ARB_DATA 2'h0
`define ARB_RSTART 2'h1
`define ARB_STOP_TRY 2'h2
`define ARB_STOP_SEEN 2'h3

`endif

// [hdl/bus_cond_detect.v]
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for both wires, then edge and start/stop decode
module bus_cond_detect (
  input wire ref_clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output wire scl_s,
  output wire sda_s,
  output wire scl_rise,
  output wire scl_fall,
  output wire start_seen,
  output wire stop_seen
);
  reg [1:0] scl_meta_q; // [0] is read only by [1]
  reg [1:0] sda_meta_q;
  reg scl_last_q; // previous synchronised level
  reg sda_last_q;

  // sync chain; released bus idles high so reset to 1
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_meta_q <= 2'h3;
      sda_meta_q <= 2'h3;
      scl_last_q <= 1'b1;
      sda_last_q <= 1'b1;
    end else begin
      scl_meta_q <= {scl_meta_q[0], scl_in};
      sda_meta_q <= {sda_meta_q[0], sda_in};
      scl_last_q <= scl_meta_q[1];
      sda_last_q <= sda_meta_q[1];
    end
  end

  assign scl_s = scl_meta_q[1];
  assign sda_s = sda_meta_q[1];
  assign scl_rise = scl_meta_q[1] & ~scl_last_q;
  assign scl_fall = ~scl_meta_q[1] & scl_last_q;
  // sda moving while scl stays high marks a condition
  assign start_seen = scl_meta_q[1] & scl_last_q & ~sda_meta_q[1] & sda_last_q;
  assign stop_seen = scl_meta_q[1] & scl_last_q & sda_meta_q[1] & ~sda_last_q;
endmodule

`default_nettype wire

// [hdl/smbus_slave_status_engine.v]
`include "smbus_slave_regs.vh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - start, address plus direction, data, stop
// - receiver pulls sda low for ack
// - arbitration leaves exactly one master
// - lines only pulled low or released
// - write address enters receiver, interrupts, requests ack
// - nacked address mutes slave until next start
// - byte ack comes from software ack bit
// - receive interrupt before ack, transmit after
// - stop ends slave receiver operation
// - data write while receiving switches to transmit
// - read address interrupts; acked, loaded bytes shift out
// - no data write falls back to receiver
// - data write after nack flags error
// - sent byte reports 0100 with master ack
// - stop as transmitter reports 0101
// - lost repeated start reports 0010, arb lost
// - lost stop attempt or stop reports 0001
// - stop as receiver reports 0001, flags clear
// - received data byte reports 0000, ack requested
// - start bit after loss retries, else abandons
// - flag columns shared with master status rows
module smbus_slave_status_engine (
  input wire ref_clk,
  input wire rst,
  input wire scl_i,
  output reg scl_o_q,
  output reg scl_oe_n_q,
  input wire sda_i,
  output reg sda_o_q,
  output reg sda_oe_n_q,
  input wire slave_event_inhibit,
  input wire ack_bit,
  input wire start_request_bit,
  input wire si_clear,
  input wire data_wr,
  input wire [7:0] data_wr_byte,
  input wire arb_event,
  input wire [1:0] arb_kind,
  output reg si_q,
  output reg [3:0] status_vector_q,
  output reg ack_request_flag_q,
  output reg arbitration_lost_flag_q,
  output reg ack_q,
  output reg [7:0] rx_data_q,
  output reg slave_rx_q,
  output reg slave_tx_q,
  output reg master_retry_q
);
  // slave sequencer states
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_ADDR = 4'h1;
  localparam [3:0] S_ADDR_WAIT = 4'h2;
  localparam [3:0] S_ACK_BIT = 4'h3;
  localparam [3:0] S_RX_DATA = 4'h4;
  localparam [3:0] S_RX_WAIT = 4'h5;
  localparam [3:0] S_TX_DATA = 4'h6;
  localparam [3:0] S_TX_ACK = 4'h7;
  localparam [3:0] S_TX_WAIT = 4'h8;
  localparam [3:0] S_MUTED = 4'h9;

  wire scl_s; // synchronised clock level
  wire sda_s; // synchronised data level
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;

  reg [3:0] state_q; // sequencer state
  reg [3:0] bit_cnt_q; // bits moved in current byte
  reg [7:0] shift_q; // receive shifter
  reg [7:0] tx_q; // transmit shifter
  reg tx_loaded_q; // software loaded a byte this pause
  reg nack_seen_q; // master answered the last byte with nack
  reg scl_hold_q; // stretch scl while software decides
  reg arb_pend_q; // loss as master awaiting next address
  reg si_set; // one-cycle set of the interrupt flag
  reg [3:0] sv_set; // vector loaded with the set
  reg ack_request_flag_set; // request flag loaded with the set
  reg arb_set; // arb-lost flag loaded with the set

  bus_cond_detect u_cond (
    .ref_clk(ref_clk),
    .rst(rst),
    .scl_in(scl_i),
    .sda_in(sda_i),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  // true when the sequencer counts as an addressed receiver
  function rx_active;
    input [3:0] st;
    input rx_flag;
    begin
      rx_active = rx_flag & (st != S_IDLE) & (st != S_MUTED);
    end
  endfunction

  // status events: which row to report this cycle
  always @* begin
    si_set = 1'b0;
    sv_set = `SV_SLV_DATA;
    ack_request_flag_set = 1'b0;
    arb_set = 1'b0;
    if (arb_event) begin
      // master engine lost the bus; same flag columns as slave rows
      si_set = 1'b1;
      arb_set = 1'b1;
      case (arb_kind)
        `ARB_DATA: begin
          sv_set = `SV_SLV_DATA;
          ack_request_flag_set = 1'b1;
        end
        `ARB_RSTART: begin
          sv_set = `SV_SLV_ADDR;
        end
        `ARB_STOP_TRY: begin
          sv_set = `SV_STOP_LOST;
          ack_request_flag_set = 1'b1;
        end
        default: begin
          sv_set = `SV_STOP_LOST;
        end
      endcase
    end else if (stop_seen && slave_tx_q) begin
      si_set = 1'b1;
      sv_set = `SV_SLV_TX_STOP;
    end else if (stop_seen && rx_active(state_q, slave_rx_q)) begin
      si_set = 1'b1;
      sv_set = `SV_STOP_LOST;
    end else if (scl_fall && bit_cnt_q == `BYTE_BITS
                 && (state_q == S_ADDR || state_q == S_RX_DATA)) begin
      // transmit side also ends with a count of eight, so gate by state
      case (state_q)
        S_ADDR: begin
          si_set = 1'b1;
          sv_set = `SV_SLV_ADDR;
          ack_request_flag_set = 1'b1;
          arb_set = arb_pend_q;
        end
        S_RX_DATA: begin
          si_set = 1'b1; // raised before the ack slot
          sv_set = `SV_SLV_DATA;
          ack_request_flag_set = 1'b1;
        end
        default: begin
          si_set = 1'b0;
        end
      endcase
    end else if (scl_fall && state_q == S_TX_ACK) begin
      si_set = 1'b1; // raised after the ack slot
      sv_set = `SV_SLV_TX_BYTE;
    end
  end

  // interrupt flag and status byte; a set in the clear cycle wins
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      si_q <= 1'b0;
      status_vector_q <= 4'h0;
      ack_request_flag_q <= 1'b0;
      arbitration_lost_flag_q <= 1'b0;
      ack_q <= 1'b0;
      rx_data_q <= 8'h00;
      master_retry_q <= 1'b0;
      arb_pend_q <= 1'b0;
    end else begin
      master_retry_q <= 1'b0;
      if (si_set) begin
        si_q <= 1'b1;
        status_vector_q <= sv_set;
        ack_request_flag_q <= ack_request_flag_set;
        arbitration_lost_flag_q <= arb_set;
        if (state_q == S_RX_DATA || state_q == S_ADDR) begin
          rx_data_q <= shift_q;
        end
        if (state_q == S_TX_ACK && !stop_seen) begin
          ack_q <= nack_seen_q ? 1'b0 : 1'b1;
        end
      end else begin
        if (si_clear) begin
          si_q <= 1'b0;
          // retry when asked, otherwise the lost transfer is dropped
          if (arbitration_lost_flag_q) begin
            master_retry_q <= start_request_bit;
          end
        end
        if (data_wr && state_q == S_TX_WAIT && nack_seen_q) begin
          arbitration_lost_flag_q <= 1'b1;
        end
      end
      // a loss as master colours the next address row
      if (arb_event) begin
        arb_pend_q <= 1'b1;
      end else if (si_set && state_q == S_ADDR) begin
        arb_pend_q <= 1'b0;
      end
    end
  end

  // slave sequencer and wire drivers
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      tx_loaded_q <= 1'b0;
      nack_seen_q <= 1'b0;
      scl_hold_q <= 1'b0;
      slave_rx_q <= 1'b0;
      slave_tx_q <= 1'b0;
      scl_o_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
      sda_o_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else begin
      // pins only ever pull low; oe_n high means released
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
      scl_oe_n_q <= ~(scl_hold_q | si_set & (sv_set != `SV_SLV_TX_STOP)
                      & (sv_set != `SV_STOP_LOST) & ~arb_event);
      if (si_set && !arb_event && sv_set != `SV_SLV_TX_STOP
          && sv_set != `SV_STOP_LOST) begin
        scl_hold_q <= 1'b1;
      end
      // software may load the transmit byte during any pause
      if (data_wr) begin
        tx_q <= data_wr_byte;
        tx_loaded_q <= 1'b1;
      end
      if (start_seen) begin
        // a start re-arms the slave, even when muted, unless slave_event_inhibit holds it idle
        bit_cnt_q <= 4'h0;
        scl_hold_q <= 1'b0;
        sda_oe_n_q <= 1'b1;
        slave_rx_q <= 1'b0;
        slave_tx_q <= 1'b0;
        tx_loaded_q <= 1'b0;
        state_q <= slave_event_inhibit ? S_IDLE : S_ADDR;
      end else if (stop_seen) begin
        // stop closes any slave transfer
        state_q <= S_IDLE;
        scl_hold_q <= 1'b0;
        sda_oe_n_q <= 1'b1;
        slave_rx_q <= 1'b0;
        slave_tx_q <= 1'b0;
      end else begin
        case (state_q)
          S_ADDR, S_RX_DATA: begin
            // shift in msb first on each rising scl
            if (scl_rise && bit_cnt_q != `BYTE_BITS) begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (scl_fall && bit_cnt_q == `BYTE_BITS) begin
              tx_loaded_q <= 1'b0;
              if (state_q == S_ADDR) begin
                state_q <= S_ADDR_WAIT;
                slave_rx_q <= 1'b1;
              end else begin
                state_q <= S_RX_WAIT;
              end
            end
          end
          S_ADDR_WAIT: begin
            if (si_clear && !si_set) begin
              scl_hold_q <= 1'b0;
              if (!ack_bit) begin
                // declined address: stay silent until a start
                state_q <= S_MUTED;
                slave_rx_q <= 1'b0;
              end else begin
                sda_oe_n_q <= 1'b0; // pull sda for ack
                state_q <= S_ACK_BIT;
                bit_cnt_q <= 4'h0;
              end
            end
          end
          S_RX_WAIT: begin
            if (si_clear && !si_set) begin
              scl_hold_q <= 1'b0;
              sda_oe_n_q <= ~ack_bit;
              state_q <= S_ACK_BIT;
              bit_cnt_q <= 4'h0;
            end
          end
          S_ACK_BIT: begin
            // end of the ack slot decides the direction that follows
            if (scl_fall) begin
              if (tx_loaded_q || (shift_q[`ADDR_DIR_BIT] == `DIR_READ
                  && !slave_rx_q)) begin
                state_q <= S_TX_DATA;
                slave_rx_q <= 1'b0;
                slave_tx_q <= 1'b1;
                tx_loaded_q <= 1'b0;
                sda_oe_n_q <= tx_q[7];
              end else begin
                state_q <= S_RX_DATA;
                sda_oe_n_q <= 1'b1;
              end
            end
          end
          S_TX_DATA: begin
            // next bit goes out on each falling scl
            if (scl_fall) begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
              if (bit_cnt_q == `BYTE_BITS - 4'h1) begin
                sda_oe_n_q <= 1'b1;
                state_q <= S_TX_ACK;
              end else begin
                sda_oe_n_q <= tx_q[6];
                tx_q <= {tx_q[6:0], 1'b1};
              end
            end
          end
          S_TX_ACK: begin
            // high sda in the ack slot is a nack
            if (scl_rise) begin
              nack_seen_q <= sda_s;
            end
            if (scl_fall) begin
              tx_loaded_q <= 1'b0;
              state_q <= S_TX_WAIT;
            end
          end
          S_TX_WAIT: begin
            if (si_clear && !si_set) begin
              scl_hold_q <= 1'b0;
              bit_cnt_q <= 4'h0;
              if (tx_loaded_q || data_wr) begin
                tx_loaded_q <= 1'b0;
                sda_oe_n_q <= data_wr ? data_wr_byte[7] : tx_q[7];
                state_q <= S_TX_DATA;
              end else begin
                // nothing loaded: listen as a receiver again
                state_q <= S_RX_DATA;
                slave_tx_q <= 1'b0;
                slave_rx_q <= 1'b1;
              end
            end
          end
          S_MUTED: begin
            sda_oe_n_q <= 1'b1;
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule

`default_nettype wire

// [test/smbus_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
// bus master model; an output of 1 releases the line
module smbus_master_model (
  input wire logic ref_clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_m,
  output logic sda_m,
  output logic stuck
);
  initial {scl_m, sda_m, stuck} = 3'b110; // both lines float high at rest
  // release scl and wait out slave stretching, bounded
  task automatic rise;
    int n = 0;
    scl_m = 1'b1;
    while (scl !== 1'b1 && n < 8000) begin
      @(negedge ref_clk);
      n++;
    end
    stuck |= scl !== 1'b1;
  endtask
  // data moves only while scl is low, sampled late in the high phase
  task automatic put(input logic b, output logic r);
    #50 sda_m = b;
    #50 rise();
    #100 r = sda;
    scl_m = 1'b0;
  endtask
  task automatic start;
    @(negedge ref_clk);
    sda_m = 1'b0;
    #100 scl_m = 1'b0;
  endtask
  task automatic stop;
    #50 sda_m = 1'b0;
    #50 rise();
    #100 sda_m = 1'b1;
  endtask
  // msb first, ninth slot is the ack
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] g, output logic a);
    for (int i = 7; i >= 0; i--)
      put(d[i], g[i]);
    put(ai, a);
  endtask
endmodule
`default_nettype wire

// [test/smbus_slave_checker_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "smbus_slave_regs.vh"
// watches the engine ports only
module smbus_slave_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_o_q,
  input wire logic scl_oe_n_q,
  input wire logic sda_o_q,
  input wire logic si_q,
  input wire logic si_clear,
  input wire logic [3:0] status_vector_q,
  input wire logic ack_request_flag_q,
  input wire logic arbitration_lost_flag_q,
  input wire logic arb_event,
  input wire logic [1:0] arb_kind,
  input wire logic start_request_bit,
  input wire logic master_retry_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // pins are only ever pulled low
  property p_pull; scl_o_q == 1'b0 && sda_o_q == 1'b0; endproperty
  a_pull: assert property (p_pull) else $error("line driven high");
  // slave byte and address events stretch scl
  property p_hold; $rose(si_q) && ack_request_flag_q && !arbitration_lost_flag_q
    |-> ##[0:1] !scl_oe_n_q; endproperty
  a_hold: assert property (p_hold) else $error("scl not held");
  property p_addr; $rose(si_q) && status_vector_q == `SV_SLV_ADDR && !arbitration_lost_flag_q
    |-> ack_request_flag_q; endproperty
  a_addr: assert property (p_addr) else $error("address flags");
  property p_rxstop; $rose(si_q) && status_vector_q == `SV_STOP_LOST
    && !arbitration_lost_flag_q |-> !ack_request_flag_q; endproperty
  a_rxstop: assert property (p_rxstop) else $error("stop flags");
  property p_txbyte; $rose(si_q) && (status_vector_q == `SV_SLV_TX_BYTE
    || status_vector_q == `SV_SLV_TX_STOP) |-> !ack_request_flag_q; endproperty
  a_txbyte: assert property (p_txbyte) else $error("transmit flags");
  property p_rstart; arb_event && arb_kind == `ARB_RSTART |-> ##[1:3] (si_q
    && status_vector_q == `SV_SLV_ADDR && !ack_request_flag_q && arbitration_lost_flag_q);
  endproperty
  a_rstart: assert property (p_rstart) else $error("lost restart");
  property p_stoptry; arb_event && arb_kind == `ARB_STOP_TRY |-> ##[1:3] (si_q
    && status_vector_q == `SV_STOP_LOST && ack_request_flag_q && arbitration_lost_flag_q);
  endproperty
  a_stoptry: assert property (p_stoptry) else $error("lost stop");
  property p_retry; si_q && si_clear && arbitration_lost_flag_q && start_request_bit
    |-> ##[1:2] master_retry_q; endproperty
  a_retry: assert property (p_retry) else $error("no retry");
  c_tx: cover property ($rose(si_q) && status_vector_q == `SV_SLV_TX_BYTE);
  c_stop: cover property ($rose(si_q) && status_vector_q == `SV_SLV_TX_STOP);
  c_retry: cover property (master_retry_q);
endmodule
bind smbus_slave_status_engine smbus_slave_checker chk_inst (
  .ref_clk(ref_clk), .rst(rst), .scl_o_q(scl_o_q), .scl_oe_n_q(scl_oe_n_q),
  .sda_o_q(sda_o_q), .si_q(si_q), .si_clear(si_clear), .status_vector_q(status_vector_q),
  .ack_request_flag_q(ack_request_flag_q), .arbitration_lost_flag_q(arbitration_lost_flag_q),
  .arb_event(arb_event), .arb_kind(arb_kind), .start_request_bit(start_request_bit),
  .master_retry_q(master_retry_q)
);
`default_nettype wire

// [test/smbus_slave_status_engine_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "smbus_slave_regs.vh"
module smbus_slave_status_engine_bench;
  logic ref_clk = 1'b0, rst = 1'b1, slave_event_inhibit = 1'b0, ack_bit = 1'b1;
  logic start_request_bit = 1'b0, si_clear = 1'b0, data_wr = 1'b0, arb_event = 1'b0;
  logic [1:0] arb_kind = 2'h0;
  logic [7:0] data_wr_byte = 8'h96;
  logic tx_load = 1'b1; // software answers reads with data
  logic [1:0] resp_q = 2'h0; // software reply step
  logic [14:0] ev_q[$]; // vector, ack_request_flag, arbitration_lost_flag, ack, byte
  logic [7:0] got;
  logic [5:0] arb_exp[4] = '{{`SV_SLV_DATA, 2'b11}, {`SV_SLV_ADDR, 2'b01},
    {`SV_STOP_LOST, 2'b11}, {`SV_STOP_LOST, 2'b01}};
  int num_errors = 0, n_compared = 0, retries = 0;
  wire scl_o_q, scl_oe_n_q, sda_o_q, sda_oe_n_q, si_q, ack_q, master_retry_q;
  wire ack_request_flag_q, arbitration_lost_flag_q, scl_m, sda_m, stuck;
  wire [3:0] status_vector_q;
  wire [7:0] rx_data_q;
  wire scl_w = scl_m & (scl_oe_n_q | scl_o_q); // wired-and with pull-up
  wire sda_w = sda_m & (sda_oe_n_q | sda_o_q);
  always #12.5 ref_clk = ~ref_clk;
  smbus_slave_status_engine smbus_slave_status_engine_inst (
    .ref_clk(ref_clk), .rst(rst), .scl_i(scl_w), .scl_o_q(scl_o_q), .scl_oe_n_q(scl_oe_n_q),
    .sda_i(sda_w), .sda_o_q(sda_o_q), .sda_oe_n_q(sda_oe_n_q), .ack_bit(ack_bit),
    .slave_event_inhibit(slave_event_inhibit), .start_request_bit(start_request_bit),
    .si_clear(si_clear), .data_wr(data_wr), .data_wr_byte(data_wr_byte), .si_q(si_q),
    .arb_event(arb_event), .arb_kind(arb_kind), .status_vector_q(status_vector_q),
    .ack_request_flag_q(ack_request_flag_q), .arbitration_lost_flag_q(arbitration_lost_flag_q),
    .ack_q(ack_q), .rx_data_q(rx_data_q), .slave_rx_q(), .slave_tx_q(),
    .master_retry_q(master_retry_q)
  );
  smbus_master_model smbus_master_model_inst (
    .ref_clk(ref_clk), .scl(scl_w), .sda(sda_w), .scl_m(scl_m), .sda_m(sda_m), .stuck(stuck)
  );
  // software: log the event, load a byte when due, then clear
  always @(posedge ref_clk) begin
    if (resp_q == 2'h0 && si_q === 1'b1)
      ev_q.push_back({status_vector_q, ack_request_flag_q, arbitration_lost_flag_q, ack_q,
        rx_data_q});
    resp_q <= (resp_q == 2'h0 && si_q !== 1'b1) ? 2'h0 : resp_q + 2'h1;
    data_wr <= resp_q == 2'h1 && tx_load && ((status_vector_q == `SV_SLV_ADDR && rx_data_q[0])
      || (status_vector_q == `SV_SLV_TX_BYTE && ack_q));
    si_clear <= resp_q == 2'h2;
    if (master_retry_q === 1'b1)
      retries++;
  end
  task close_out;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task check(input string what, input logic [14:0] seen, input logic [14:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task go;
    smbus_master_model_inst.start();
  endtask
  task fin;
    smbus_master_model_inst.stop();
  endtask
  // one master byte; compare the ack level seen on the wire
  task xb(input logic [7:0] d, input logic ai, input logic ea);
    logic a;
    smbus_master_model_inst.xfer(d, ai, got, a);
    check("ack slot", 15'(a), 15'(ea));
  endtask
  task wait_ev(input int n);
    int k;
    k = 0;
    while (ev_q.size() < n && k < 20000) begin
      @(posedge ref_clk);
      k++;
    end
    if (ev_q.size() < n) begin
      num_errors++;
      close_out;
    end
  endtask
  task ev(input logic [14:0] exp, input logic [14:0] mask);
    logic [14:0] g;
    g = ev_q.pop_front();
    check("event", g & mask, exp & mask);
  endtask
  task quiet(input int n);
    repeat (300) @(posedge ref_clk);
    check("event count", 15'(ev_q.size()), 15'(n));
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    // write: address, one byte, stop
    go;
    xb(8'h5A, 1'b1, 1'b0);
    xb(8'hC3, 1'b1, 1'b0);
    fin;
    wait_ev(3);
    ev({`SV_SLV_ADDR, 3'b100, 8'h5A}, 15'h7EFF);
    ev({`SV_SLV_DATA, 3'b100, 8'hC3}, 15'h7EFF);
    ev({`SV_STOP_LOST, 3'b000, 8'h00}, 15'h7E00);
    // read: master acks the first byte, nacks the second
    go;
    xb(8'hA5, 1'b1, 1'b0);
    xb(8'hFF, 1'b0, 1'b0);
    check("read byte", 15'(got), 15'h96);
    xb(8'hFF, 1'b1, 1'b1);
    check("read byte", 15'(got), 15'h96);
    fin;
    wait_ev(4);
    ev({`SV_SLV_ADDR, 3'b100, 8'hA5}, 15'h7EFF);
    ev({`SV_SLV_TX_BYTE, 3'b001, 8'h00}, 15'h7F00);
    ev({`SV_SLV_TX_BYTE, 3'b000, 8'h00}, 15'h7F00);
    ev({`SV_STOP_LOST, 3'b000, 8'h00}, 15'h7E00);
    // read ended by stop while still loaded as transmitter
    go;
    xb(8'hA5, 1'b1, 1'b0);
    xb(8'hFF, 1'b0, 1'b0);
    check("read byte", 15'(got), 15'h96);
    fin;
    wait_ev(3);
    ev({`SV_SLV_ADDR, 3'b100, 8'hA5}, 15'h7EFF);
    ev({`SV_SLV_TX_BYTE, 3'b001, 8'h00}, 15'h7F00);
    ev({`SV_SLV_TX_STOP, 3'b000, 8'h00}, 15'h7C00);
    // declined address: silent until the next start
    @(posedge ref_clk);
    ack_bit <= 1'b0;
    go;
    xb(8'h5A, 1'b1, 1'b1);
    xb(8'hC3, 1'b1, 1'b1);
    fin;
    quiet(1);
    ev({`SV_SLV_ADDR, 3'b100, 8'h5A}, 15'h7EFF);
    // inhibited slave ignores the transfer
    @(posedge ref_clk);
    ack_bit <= 1'b1;
    slave_event_inhibit <= 1'b1;
    go;
    xb(8'h5A, 1'b1, 1'b1);
    fin;
    quiet(0);
    @(posedge ref_clk);
    slave_event_inhibit <= 1'b0;
    tx_load <= 1'b0;
    // each kind of arbitration loss; odd kinds ask for a retry
    for (int k = 0; k < 4; k++) begin
      repeat (6) @(posedge ref_clk);
      arb_event <= 1'b1;
      arb_kind <= 2'(k);
      start_request_bit <= k[0];
      @(posedge ref_clk);
      arb_event <= 1'b0;
      wait_ev(1);
      ev({arb_exp[k], 9'h000}, 15'h7E00);
    end
    repeat (10) @(posedge ref_clk);
    check("retry pulses", 15'(retries), 15'h2);
    check("scl stretch bound", 15'(stuck), 15'h0);
    close_out;
  end
endmodule
`default_nettype wire
